// ### rtl/spgc_ctrl.sv
// Port steering, link status, interrupt and GPIO control of the serializer
`timescale 1ns/1ps
module spgc_ctrl (
    input  wire logic                      CLK_SYS_I,
    input  wire logic                      RST_N_I,
    input  wire spgc_pkg::spgc_reg_req_type REG_REQ_I,
    output logic                           REG_ACK_O,
    output logic [7:0]                     REG_RDATA_O,
    input  wire logic [1:0]                LINK_FAULT_I,
    input  wire logic                      TWO_LANE_I,
    input  wire logic                      REMOTE_INT_IN_N_I,
    output logic                           REMOTE_INT_MIRROR_O,
    output logic                           INTERRUPT_OUT_N_O,
    input  wire logic [3:0]                GPIO_I,
    output spgc_pkg::spgc_pins_type        GPIO_O,
    output logic [3:0]                     FWD_GPIO_O,
    input  wire logic [3:0]                D_GPIO_I,
    output spgc_pkg::spgc_pins_type        D_GPIO_O,
    output logic [3:0]                     FWD_D_GPIO_O,
    input  wire logic                      BC_FRAME_I,
    input  wire logic [3:0]                BC_GPIO_I,
    input  wire logic [3:0]                BC_D_GPIO_I,
    input  wire logic [2:0]                CC_MODE_I,
    input  wire logic [3:0]                REG_GPIO_I,
    output spgc_pkg::spgc_pins_type        REG_GPIO_O,
    input  wire logic [3:0]                AUDIO_IN_I,
    output logic [3:0]                     AUDIO_DATA_O
);
    import spgc_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic is_dup(input logic [7:0] a);
        return (a == ADDR_GPIO0) || (a == ADDR_GPIO12) || (a == ADDR_GPIO3);
    endfunction : is_dup

    function automatic logic [1:0] dup_idx(input logic [7:0] a);
        logic [1:0] r;
        r = 2'h0;
        if (a == ADDR_GPIO12) begin
            r = 2'h1;
        end else if (a == ADDR_GPIO3) begin
            r = 2'h2;
        end
        return r;
    endfunction : dup_idx

    // Pin drive from a nibble; back code only honoured on link GPIOs
    function automatic logic [1:0] pin_drive(input logic [3:0] cfg, input logic back_ok,
                                             input logic bc_val);
        logic [1:0] r;
        r = 2'b10;
        if (cfg == GPIO_OUT_L) begin
            r = 2'b00;
        end else if (cfg == GPIO_OUT_H) begin
            r = 2'b01;
        end else if (back_ok && cfg == GPIO_BACK) begin
            r = {1'b0, bc_val};
        end
        return r;
    endfunction : pin_drive

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0] psel_q;
    logic [7:0] int_ctrl_q;
    logic [7:0] int_stat_q;
    logic [7:0] int_stat_d;
    logic [7:0] rgpio_q [PORT_N];
    logic [7:0] gcfg_q  [PORT_N][DUP_N];
    logic [7:0] rdata_q;
    logic [1:0] link_ok_q;
    logic       rem_prev_q;
    logic       mirror_q;
    logic       int_n_q;
    logic [3:0] bc_q;
    logic [3:0] dbc_q;
    logic [3:0] gin_q;
    logic [3:0] rgin_q;
    logic [3:0] d_mask;
    logic       alt_en;
    logic       acc_ok;
    logic       wr_ok;
    logic       rd_ok;
    logic [1:0] wr_ports;
    logic       rd_port;
    logic       rem_set;
    logic       link_set;
    logic       stat_clr;

    // ------------------------------------------------------------------
    // Access steering
    // ------------------------------------------------------------------
    assign alt_en = psel_q[PSEL_ALT_EN_BIT];
    // Second address is only answered while enabled
    assign acc_ok    = (REG_REQ_I.wr || REG_REQ_I.rd) && (!REG_REQ_I.alt || alt_en);
    assign wr_ok     = acc_ok && REG_REQ_I.wr;
    assign rd_ok     = acc_ok && REG_REQ_I.rd && !REG_REQ_I.wr;
    assign REG_ACK_O = acc_ok;

    always_comb begin
        if (alt_en) begin
            wr_ports = REG_REQ_I.alt ? 2'b10 : 2'b01;
            rd_port  = REG_REQ_I.alt;
        end else begin
            wr_ports = {psel_q[PSEL_P1_BIT], psel_q[PSEL_P0_BIT]};
            rd_port  = psel_q[PSEL_P1_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Common registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            psel_q     <= RST_PORT_SEL;
            int_ctrl_q <= RST_INT_CTRL;
            rgpio_q[0] <= RST_GPIO_CFG;
            rgpio_q[1] <= RST_GPIO_CFG;
        end else if (wr_ok) begin
            // Reached whatever the selects hold
            unique case (REG_REQ_I.addr)
                ADDR_PORT_SEL: psel_q     <= REG_REQ_I.wdata;
                ADDR_INT_CTRL: int_ctrl_q <= REG_REQ_I.wdata;
                ADDR_RGPIO56:  rgpio_q[0] <= REG_REQ_I.wdata;
                ADDR_RGPIO78:  rgpio_q[1] <= REG_REQ_I.wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Duplicated per-port GPIO configuration
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            for (int p = 0; p < PORT_N; p++) begin
                for (int i = 0; i < DUP_N; i++) begin
                    gcfg_q[p][i] <= RST_GPIO_CFG;
                end
            end
        end else if (wr_ok && is_dup(REG_REQ_I.addr)) begin
            for (int p = 0; p < PORT_N; p++) begin
                if (wr_ports[p]) begin
                    gcfg_q[p][dup_idx(REG_REQ_I.addr)] <= REG_REQ_I.wdata;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            rdata_q <= 8'h00;
        end else if (rd_ok) begin
            if (is_dup(REG_REQ_I.addr)) begin
                rdata_q <= gcfg_q[rd_port][dup_idx(REG_REQ_I.addr)];
            end else begin
                unique case (REG_REQ_I.addr)
                    ADDR_LINK_STAT: rdata_q <= {7'h00, link_ok_q[rd_port]};
                    ADDR_RGPIO56:   rdata_q <= rgpio_q[0];
                    ADDR_RGPIO78:   rdata_q <= rgpio_q[1];
                    ADDR_IN_STATE:  rdata_q <= {rgin_q[2:0], 1'b0, gin_q};
                    ADDR_IN8:       rdata_q <= {7'h00, rgin_q[3]};
                    ADDR_PORT_SEL:  rdata_q <= psel_q;
                    ADDR_INT_CTRL:  rdata_q <= int_ctrl_q;
                    ADDR_INT_STAT:  rdata_q <= int_stat_q;
                    default:        rdata_q <= 8'h00;
                endcase
            end
        end
    end
    assign REG_RDATA_O = rdata_q;

    // ------------------------------------------------------------------
    // Link detect
    // ------------------------------------------------------------------
    // Fault kind is not decoded; one bit per port
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            link_ok_q <= 2'b00;
        end else begin
            link_ok_q <= ~LINK_FAULT_I;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    assign rem_set  = rem_prev_q && !REMOTE_INT_IN_N_I
                      && int_ctrl_q[INT_GLOBAL_BIT] && int_ctrl_q[INT_REMOTE_BIT];
    assign link_set = link_ok_q[0] && LINK_FAULT_I[0]
                      && int_ctrl_q[INT_GLOBAL_BIT] && int_ctrl_q[INT_LINK_BIT];
    assign stat_clr = rd_ok && (REG_REQ_I.addr == ADDR_INT_STAT);

    // New events win over the clearing read
    always_comb begin
        int_stat_d = stat_clr ? RST_INT_STAT : int_stat_q;
        if (rem_set) begin
            int_stat_d[INT_REMOTE_BIT] = 1'b1;
            int_stat_d[INT_GLOBAL_BIT] = 1'b1;
        end
        if (link_set) begin
            int_stat_d[INT_LINK_BIT]   = 1'b1;
            int_stat_d[INT_GLOBAL_BIT] = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            int_stat_q <= RST_INT_STAT;
            int_n_q    <= 1'b1;
            rem_prev_q <= 1'b1;
        end else begin
            int_stat_q <= int_stat_d;
            int_n_q    <= !int_stat_d[INT_GLOBAL_BIT];
            rem_prev_q <= REMOTE_INT_IN_N_I;
        end
    end
    assign INTERRUPT_OUT_N_O = int_n_q;

    // No clear needed: level copy, held high while port 0 link is not detected
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            mirror_q <= 1'b1;
        end else begin
            mirror_q <= link_ok_q[0] ? REMOTE_INT_IN_N_I : 1'b1;
        end
    end
    assign REMOTE_INT_MIRROR_O = mirror_q;

    // ------------------------------------------------------------------
    // Back-channel GPIO capture
    // ------------------------------------------------------------------
    always_comb begin
        unique case (CC_MODE_I)
            CC_NORMAL: d_mask = MASK_4;
            CC_FAST4:  d_mask = MASK_4;
            CC_FAST2:  d_mask = MASK_2;
            CC_FAST1:  d_mask = MASK_1;
            default:   d_mask = MASK_4;
        endcase
    end

    // Frame rate is set remotely; capture is per frame, secondary bits masked by the rate mode
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            bc_q  <= 4'h0;
            dbc_q <= 4'h0;
        end else if (BC_FRAME_I) begin
            bc_q <= BC_GPIO_I;
            if (TWO_LANE_I) begin
                dbc_q <= (BC_D_GPIO_I & d_mask) | (dbc_q & ~d_mask);
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    logic [3:0] pcfg [PORT_N][GPIO_N];
    logic [3:0] rcfg [GPIO_N];
    always_comb begin
        for (int p = 0; p < PORT_N; p++) begin
            pcfg[p][0] = gcfg_q[p][0][3:0];
            pcfg[p][1] = gcfg_q[p][1][3:0];
            pcfg[p][2] = gcfg_q[p][1][7:4];
            pcfg[p][3] = gcfg_q[p][2][3:0];
        end
        for (int i = 0; i < GPIO_N; i++) begin
            rcfg[i] = rgpio_q[i / 2][(i % 2) * NIB_W +: NIB_W];
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            GPIO_O       <= '{out: 4'h0, oe_n: 4'hF};
            D_GPIO_O     <= '{out: 4'h0, oe_n: 4'hF};
            REG_GPIO_O   <= '{out: 4'h0, oe_n: 4'hF};
            FWD_GPIO_O   <= 4'h0;
            FWD_D_GPIO_O <= 4'h0;
            AUDIO_DATA_O <= 4'h0;
            gin_q        <= 4'h0;
            rgin_q       <= 4'h0;
        end else begin
            gin_q  <= GPIO_I;
            rgin_q <= REG_GPIO_I;
            for (int i = 0; i < GPIO_N; i++) begin
                {GPIO_O.oe_n[i], GPIO_O.out[i]}
                    <= pin_drive(pcfg[0][i], 1'b1, bc_q[i]);
                {D_GPIO_O.oe_n[i], D_GPIO_O.out[i]} <= TWO_LANE_I
                    ? pin_drive(pcfg[1][i], 1'b1, dbc_q[i]) : 2'b10;
                {REG_GPIO_O.oe_n[i], REG_GPIO_O.out[i]}
                    <= pin_drive(rcfg[i], 1'b0, 1'b0);
                FWD_GPIO_O[i]   <= (pcfg[0][i] == GPIO_FWD) && GPIO_I[i];
                FWD_D_GPIO_O[i] <= TWO_LANE_I && (pcfg[1][i] == GPIO_FWD)
                                   && D_GPIO_I[i];
                // GPIO mode takes the shared pin from the audio path
                AUDIO_DATA_O[i] <= (rcfg[i] == GPIO_OUT_L || rcfg[i] == GPIO_OUT_H
                                    || rcfg[i] == GPIO_IN) ? 1'b0 : AUDIO_IN_I[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);

    sequence seq_stat_read;
        rd_ok && REG_REQ_I.addr == ADDR_INT_STAT && !rem_set && !link_set;
    endsequence

    sequence seq_remote_fall;
        rem_prev_q && !REMOTE_INT_IN_N_I && int_ctrl_q[INT_GLOBAL_BIT]
        && int_ctrl_q[INT_REMOTE_BIT];
    endsequence

    a_both_sel_read: assert property (
        rd_ok && !alt_en && psel_q[1:0] == 2'b11 && REG_REQ_I.addr == ADDR_GPIO0
        |=> REG_RDATA_O == $past(gcfg_q[1][0]))
        else $error("both selects did not read second port");

    a_dual_write: assert property (
        wr_ok && !alt_en && psel_q[1:0] == 2'b11 && REG_REQ_I.addr == ADDR_GPIO0
        |=> gcfg_q[0][0] == $past(REG_REQ_I.wdata) && gcfg_q[1][0] == $past(REG_REQ_I.wdata))
        else $error("dual write missed a port");

    a_common_write: assert property (
        wr_ok && psel_q[1:0] == 2'b00 && REG_REQ_I.addr == ADDR_INT_CTRL
        |=> int_ctrl_q == $past(REG_REQ_I.wdata))
        else $error("common register not written");

    a_alt_route: assert property (
        wr_ok && alt_en && REG_REQ_I.alt && REG_REQ_I.addr == ADDR_GPIO0
        |=> gcfg_q[0][0] == $past(gcfg_q[0][0]) && gcfg_q[1][0] == $past(REG_REQ_I.wdata))
        else $error("second address write misrouted");

    a_link_status: assert property (
        LINK_FAULT_I[0] |=> !link_ok_q[0])
        else $error("fault did not clear link detect");

    a_remote_int: assert property (
        seq_remote_fall |=> !INTERRUPT_OUT_N_O)
        else $error("remote interrupt not signalled");

    a_stat_clear: assert property (
        seq_stat_read |=> INTERRUPT_OUT_N_O && int_stat_q == RST_INT_STAT)
        else $error("status read did not release interrupt");

    a_int_hold: assert property (
        !INTERRUPT_OUT_N_O && !stat_clr |=> !INTERRUPT_OUT_N_O)
        else $error("interrupt released without read");

    a_mirror_follow: assert property (
        ##1 REMOTE_INT_MIRROR_O == ($past(link_ok_q[0]) ? $past(REMOTE_INT_IN_N_I) : 1'b1))
        else $error("mirror does not follow remote input");

    a_single_lane: assert property (
        !TWO_LANE_I |=> D_GPIO_O.oe_n == 4'hF && FWD_D_GPIO_O == 4'h0)
        else $error("secondary GPIO active in one-lane mode");

    a_reset_dflt: assert property (
        $rose(RST_N_I) |-> psel_q == RST_PORT_SEL && int_ctrl_q == RST_INT_CTRL)
        else $error("control registers not at default after reset");
endmodule : spgc_ctrl

// ### rtl/spgc_pkg.sv
// Constants, register map and carrier types of the serializer port/GPIO control block
package spgc_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_LINK_STAT = 8'h0C;
    localparam logic [7:0] ADDR_GPIO0     = 8'h0D;
    localparam logic [7:0] ADDR_GPIO12    = 8'h0E;
    localparam logic [7:0] ADDR_GPIO3     = 8'h0F;
    localparam logic [7:0] ADDR_RGPIO56   = 8'h10;
    localparam logic [7:0] ADDR_RGPIO78   = 8'h11;
    localparam logic [7:0] ADDR_IN_STATE  = 8'h1C;
    localparam logic [7:0] ADDR_IN8       = 8'h1D;
    localparam logic [7:0] ADDR_PORT_SEL  = 8'h1E;
    localparam logic [7:0] ADDR_INT_CTRL  = 8'hC6;
    localparam logic [7:0] ADDR_INT_STAT  = 8'hC7;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PSEL_P0_BIT     = 0;
    localparam int PSEL_P1_BIT     = 1;
    localparam int PSEL_ALT_EN_BIT = 7;
    localparam int INT_GLOBAL_BIT  = 0;
    localparam int INT_LINK_BIT    = 1;
    localparam int INT_REMOTE_BIT  = 5;
    localparam int LINK_DET_BIT    = 0;
    localparam int NIB_W           = 4;
    localparam int GPIO_N          = 4;
    localparam int PORT_N          = 2;
    localparam int DUP_N           = 3;
    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_PORT_SEL = 8'h01;
    localparam logic [7:0] RST_GPIO_CFG = 8'h00;
    localparam logic [7:0] RST_INT_CTRL = 8'h00;
    localparam logic [7:0] RST_INT_STAT = 8'h00;
    localparam logic [3:0] GPIO_FWD     = 4'h3;
    localparam logic [3:0] GPIO_BACK    = 4'h5;
    localparam logic [3:0] GPIO_OUT_L   = 4'h1;
    localparam logic [3:0] GPIO_OUT_H   = 4'h9;
    localparam logic [3:0] GPIO_IN      = 4'h3;
    localparam logic [2:0] CC_NORMAL    = 3'h0;
    localparam logic [2:0] CC_FAST4     = 3'h3;
    localparam logic [2:0] CC_FAST2     = 3'h2;
    localparam logic [2:0] CC_FAST1     = 3'h1;
    localparam logic [3:0] MASK_4       = 4'hF;
    localparam logic [3:0] MASK_2       = 4'h3;
    localparam logic [3:0] MASK_1       = 4'h1;
    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       alt;
        logic [7:0] addr;
        logic [7:0] wdata;
    } spgc_reg_req_type;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe_n;
    } spgc_pins_type;
endpackage : spgc_pkg

// ### testbench/spgc_deser_model.sv
// Behavioural model of the remote deserializer back-channel side
`timescale 1ns/1ps
module spgc_deser_model (
    input  wire logic  clk_i,
    output logic       int_n_o,
    output logic       frame_o,
    output logic [3:0] gpio_o,
    output logic [3:0] d_gpio_o,
    output logic [2:0] mode_o
);
    initial begin
        int_n_o = 1'b1;
        frame_o = 1'b0;
        gpio_o = 4'hA;
        d_gpio_o = 4'h5;
        mode_o = 3'h0;
    end
    // ------------------------------------------------------------------
    // Back-channel frame: four link GPIO bits each
    // ------------------------------------------------------------------
    task send(input logic [3:0] g, input logic [3:0] d, input logic [2:0] m);
        @(posedge clk_i);
        frame_o <= 1'b1;
        gpio_o <= g;
        d_gpio_o <= d;
        mode_o <= m;
        @(posedge clk_i);
        frame_o <= 1'b0;
        // Stale bits inverted so a late sample cannot match by chance
        gpio_o <= ~g;
        d_gpio_o <= ~d;
    endtask : send
    task irq(input logic v);
        @(posedge clk_i);
        int_n_o <= v;
    endtask : irq
endmodule : spgc_deser_model

// ### testbench/spgc_ctrl_bench.sv
// Self-checking bench of the serializer port/GPIO control block
`timescale 1ns/1ps
module spgc_ctrl_bench;
    import spgc_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic             clk = 1'b0;
    logic             rst_n = 1'b0;
    spgc_reg_req_type req = '0;
    logic [1:0]       fault = 2'b01;
    logic             two = 1'b0;
    logic [3:0]       gp_i = 4'h0;
    logic [3:0]       rg_i = 4'h0;
    logic [3:0]       au_i = 4'hF;
    logic [3:0]       dgi = 4'hF;
    logic [3:0]       fdg;
    logic             ack, ak, int_n, mir, rin, frm;
    logic [7:0]       rdata, rd;
    logic [3:0]       fwd, bg, bd, au_o;
    logic [2:0]       ccm;
    spgc_pins_type    g_o, dg_o, rg_o;
    int               n_mismatch = 0;
    int               tests_run = 0;
    int               cyc = 0;
    spgc_deser_model des (.clk_i(clk), .int_n_o(rin), .frame_o(frm), .gpio_o(bg),
        .d_gpio_o(bd), .mode_o(ccm));
    spgc_ctrl uut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .REG_REQ_I(req), .REG_ACK_O(ack),
        .REG_RDATA_O(rdata), .LINK_FAULT_I(fault), .TWO_LANE_I(two),
        .REMOTE_INT_IN_N_I(rin), .REMOTE_INT_MIRROR_O(mir), .INTERRUPT_OUT_N_O(int_n),
        .GPIO_I(gp_i), .GPIO_O(g_o), .FWD_GPIO_O(fwd), .D_GPIO_I(dgi), .D_GPIO_O(dg_o),
        .FWD_D_GPIO_O(fdg), .BC_FRAME_I(frm), .BC_GPIO_I(bg), .BC_D_GPIO_I(bd),
        .CC_MODE_I(ccm), .REG_GPIO_I(rg_i), .REG_GPIO_O(rg_o), .AUDIO_IN_I(au_i),
        .AUDIO_DATA_O(au_o));
    always #10 clk = ~clk;
    // Ceiling well above the roughly 160 cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task print_verdict();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    task chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task acc(input logic w, input logic al, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{w, !w, al, a, d};
        #1 ak = ack;
        @(posedge clk);
        req <= '0;
        #1 rd = rdata;
    endtask : acc
    task wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, 1'b0, a, d);
    endtask : wr
    task rdc(input logic al, input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, al, a, 8'h00);
        chk(rd, e);
    endtask : rdc
    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_reset();
        rdc(0, ADDR_PORT_SEL, 8'h01);
        rdc(0, ADDR_GPIO0, 8'h00);
        des.irq(1'b0);
        wt(3);
        chk({6'h0, int_n, mir}, 8'h03);
        des.irq(1'b1);
    endtask : t_reset
    task t_ports();
        wr(ADDR_PORT_SEL, 8'h03);
        wr(ADDR_GPIO0, 8'h03);
        wr(ADDR_PORT_SEL, 8'h02);
        rdc(0, ADDR_GPIO0, 8'h03);
        wr(ADDR_GPIO0, 8'h05);
        wr(ADDR_PORT_SEL, 8'h03);
        rdc(0, ADDR_GPIO0, 8'h05);
        wr(ADDR_PORT_SEL, 8'h00);
        wr(ADDR_GPIO0, 8'h09);
        wr(ADDR_INT_CTRL, 8'h21);
        rdc(0, ADDR_INT_CTRL, 8'h21);
        wr(ADDR_PORT_SEL, 8'h01);
        rdc(0, ADDR_GPIO0, 8'h03);
    endtask : t_ports
    task t_alt();
        acc(1'b1, 1'b1, ADDR_GPIO0, 8'h09);
        chk({7'h0, ak}, 8'h00);
        wr(ADDR_PORT_SEL, 8'h82);
        acc(1'b1, 1'b1, ADDR_GPIO0, 8'h01);
        wr(ADDR_GPIO0, 8'h09);
        rdc(1, ADDR_GPIO0, 8'h01);
        wr(ADDR_PORT_SEL, 8'h01);
        rdc(0, ADDR_GPIO0, 8'h09);
        chk({6'h0, g_o.out[0], g_o.oe_n[0]}, 8'h02);
    endtask : t_alt
    task t_link_irq();
        acc(1'b0, 1'b0, ADDR_LINK_STAT, 8'h00);
        chk({7'h0, rd[LINK_DET_BIT]}, 8'h00);
        @(posedge clk);
        fault <= 2'b00;
        wt(3);
        acc(1'b0, 1'b0, ADDR_LINK_STAT, 8'h00);
        chk({7'h0, rd[LINK_DET_BIT]}, 8'h01);
        des.irq(1'b0);
        wt(2);
        chk({6'h0, int_n, mir}, 8'h00);
        wt(20);
        chk({7'h0, int_n}, 8'h00);
        rdc(0, ADDR_INT_STAT, 8'h21);
        chk({6'h0, int_n, mir}, 8'h02);
        des.irq(1'b1);
        wt(2);
        chk({7'h0, mir}, 8'h01);
    endtask : t_link_irq
    task t_gpio();
        wr(ADDR_GPIO0, 8'h03);
        @(posedge clk);
        gp_i <= 4'h1;
        wt(3);
        chk({6'h0, fwd[0], g_o.oe_n[0]}, 8'h03);
        wr(ADDR_GPIO0, 8'h05);
        des.send(4'h1, 4'hF, CC_NORMAL);
        wt(3);
        chk({6'h0, g_o.out[0], g_o.oe_n[0]}, 8'h02);
        des.send(4'hE, 4'h0, CC_NORMAL);
        wt(3);
        chk({7'h0, g_o.out[0]}, 8'h00);
    endtask : t_gpio
    task t_rgpio();
        wr(ADDR_RGPIO56, 8'h91);
        wt(2);
        chk({rg_o.out[1:0], rg_o.oe_n[1:0], au_o}, 8'h8C);
        wr(ADDR_RGPIO78, 8'h33);
        @(posedge clk);
        rg_i <= 4'hC;
        wt(3);
        rdc(0, ADDR_IN_STATE, 8'h81);
        rdc(0, ADDR_IN8, 8'h01);
        chk({2'h0, rg_o.oe_n[3:2], au_o}, 8'h30);
        chk({4'h0, fwd}, 8'h00);
    endtask : t_rgpio
    task t_dlane();
        wr(ADDR_PORT_SEL, 8'h02);
        wr(ADDR_GPIO0, 8'h05);
        wr(ADDR_GPIO12, 8'h55);
        wr(ADDR_GPIO3, 8'h03);
        wt(2);
        chk({fdg, dg_o.oe_n}, 8'h0F);
        @(posedge clk);
        two <= 1'b1;
        des.send(4'h0, 4'h0, CC_NORMAL);
        des.send(4'h0, 4'h3, CC_FAST1);
        wt(3);
        chk({4'h0, dg_o.out[1:0], dg_o.oe_n[1:0]}, 8'h04);
        des.send(4'h0, 4'h3, CC_FAST2);
        wt(3);
        chk({6'h0, dg_o.out[1:0]}, 8'h03);
        chk({7'h0, g_o.oe_n[1]}, 8'h01);
        des.send(4'h0, 4'hC, CC_FAST4);
        wt(3);
        chk({fdg, dg_o.out}, 8'h84);
    endtask : t_dlane
    task t_pd();
        // Power-down hold shortened to 3 cycles; the 3 ms is the driver's duty
        @(posedge clk);
        rst_n <= 1'b0;
        wt(3);
        chk({4'h0, int_n, mir, rg_o.oe_n[1:0]}, 8'h0F);
        @(posedge clk);
        rst_n <= 1'b1;
        rdc(0, ADDR_PORT_SEL, 8'h01);
        rdc(0, ADDR_INT_CTRL, 8'h00);
    endtask : t_pd
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_ports();
        t_alt();
        t_link_irq();
        t_gpio();
        t_rgpio();
        t_dlane();
        t_pd();
        print_verdict();
    end
endmodule : spgc_ctrl_bench
